/* File: rtl/msg_fifo.sv */
// Purpose: small first-in first-out buffer for parser entries
// Assumes: depth is a power of two, at least two
// Notes: pointers carry one extra wrap bit so full and empty stay distinct
`timescale 1ns/1ps
module msg_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rstB,
  stream_if.snk inSide,
  stream_if.src outSide
);
  localparam int AW = $clog2(DEPTH);

  // refuse depths the pointer logic cannot serve
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : badDepth
    $error("msg_fifo depth must be a power of two of at least two");
  end

  typedef struct packed {
    logic [AW:0] wrPtr; // write pointer with wrap bit
    logic [AW:0] rdPtr; // read pointer with wrap bit
  } fifo_s;

  fifo_s cur_ff;
  fifo_s nxt_ff;
  logic [WIDTH-1:0] mem [DEPTH]; // storage, no reset needed
  logic full;
  logic empty;
  logic push;
  logic pop;

  // flags straight from pointers, so they never lie
  assign full = (cur_ff.wrPtr[AW] != cur_ff.rdPtr[AW]) && (cur_ff.wrPtr[AW-1:0] == cur_ff.rdPtr[AW-1:0]);
  assign empty = cur_ff.wrPtr == cur_ff.rdPtr;
  assign inSide.ready = !full;
  assign outSide.valid = !empty;
  assign outSide.data = mem[cur_ff.rdPtr[AW-1:0]];
  assign push = inSide.valid && !full;
  assign pop = outSide.ready && !empty;

  // pointer update
  always_comb begin
    nxt_ff = cur_ff;
    if (push) begin
      nxt_ff.wrPtr = cur_ff.wrPtr + 1'b1;
    end
    if (pop) begin
      nxt_ff.rdPtr = cur_ff.rdPtr + 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rstB) begin
    if (!rstB) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[cur_ff.wrPtr[AW-1:0]] <= inSide.data;
    end
  end
endmodule : msg_fifo

/* File: rtl/net_param_msg_parser.sv */
// Purpose: receive-side parser of network parameter exchange messages
// Assumes: one frame per rxLast-terminated octet run; frame type flag valid on first octet
// Notes: accepted blocks leave through an 8-entry buffer; stalls reach rxReady
`timescale 1ns/1ps
module net_param_msg_parser #(
  parameter int BUF_DEPTH = net_param_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] rxData,
  input wire logic rxValid,
  input wire logic rxLast,
  input wire logic rxUiType1,
  output logic rxReady,
  input wire logic [7:0] ownLinkAddr,
  input wire logic established,
  output logic blkValid,
  input wire logic blkReady,
  output logic [1:0] blkKind,
  output logic [7:0] blkA,
  output logic [7:0] blkB,
  output logic discardPulse,
  output logic [2:0] discardCause,
  output logic relayPulse,
  output logic [7:0] relayDst
);
  localparam int EW = net_param_pkg::ENTRY_W;

  logic [1:0] rstPipe_ff; // reset release pipeline
  logic rstSyncB; // released reset for the rest of the block
  net_param_pkg::parse_s cur_ff; // all parser state
  net_param_pkg::parse_s nxt_ff; // its next value
  logic take; // octet accepted this cycle
  logic relayHit; // message addressed to us as forwarder
  logic [7:0] lenRem; // octets left after id and length
  logic onBoundary; // frame ended exactly where a block ends

  stream_if #(.W(EW)) wrBus (); // parser to buffer
  stream_if #(.W(EW)) rdBus (); // buffer to user

  // two-stage reset release; first stage feeds only the second
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstPipe_ff <= net_param_pkg::RST_PIPE_INIT;
    end else begin
      rstPipe_ff <= {rstPipe_ff[0], 1'b1};
    end
  end
  assign rstSyncB = rstPipe_ff[1];

  // entry buffer; its full flag stalls the octet stream
  msg_fifo #(.WIDTH(EW), .DEPTH(BUF_DEPTH)) entryBuf (
    .clk(core_clk),
    .rstB(rstSyncB),
    .inSide(wrBus.snk),
    .outSide(rdBus.src)
  );

  assign blkValid = rdBus.valid;
  assign rdBus.ready = blkReady;
  assign blkKind = rdBus.data[17:16];
  assign blkA = rdBus.data[15:8];
  assign blkB = rdBus.data[7:0];
  assign discardPulse = cur_ff.discardPulse;
  assign discardCause = cur_ff.discardCause;
  assign relayPulse = cur_ff.relayPulse;
  assign relayDst = cur_ff.relayDst;

  // no octet taken while the close entry waits for room
  assign rxReady = wrBus.ready && (cur_ff.st != net_param_pkg::S_CLOSE);
  assign take = rxValid && rxReady;
  // unknown forwarder (zero) never matches, so a joiner's blind request is not relayed by us
  assign relayHit = cur_ff.fwdSeen && established && (cur_ff.fwdAddr != net_param_pkg::ADDR_UNKNOWN) &&
                    (cur_ff.fwdAddr == ownLinkAddr);
  assign lenRem = rxData - net_param_pkg::BLK_HDR_LEN;
  // a stale count must not decide this: only body states carry a live count
  assign onBoundary = (cur_ff.st inside {net_param_pkg::S_BLK_ID, net_param_pkg::S_MSG_LEN}) ||
                      (cur_ff.st == net_param_pkg::S_BLK_LEN && rxData <= net_param_pkg::BLK_HDR_LEN) ||
                      (cur_ff.st inside {net_param_pkg::S_MSG_DAT, net_param_pkg::S_BLK_DAT,
                                         net_param_pkg::S_BLK_SKIP} && cur_ff.cnt == 8'h01);

  // next-state logic: one octet per accepted beat
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.discardPulse = 1'b0;
    nxt_ff.relayPulse = 1'b0;
    wrBus.valid = 1'b0;
    wrBus.data = '0;
    if (cur_ff.st == net_param_pkg::S_CLOSE) begin
      // close entry carries status and relay mark
      wrBus.valid = 1'b1;
      wrBus.data = {net_param_pkg::KIND_CLOSE, relayHit, 5'h00, cur_ff.closeSt, cur_ff.msgId};
      if (wrBus.ready) begin
        nxt_ff.st = net_param_pkg::S_VER;
        if (relayHit) begin
          // the same path returns answers to a joiner: their header names it as destination
          nxt_ff.relayPulse = 1'b1;
          nxt_ff.relayDst = cur_ff.dstAddr;
        end
      end
    end else if (take) begin
      unique case (cur_ff.st)
        net_param_pkg::S_VER: begin
          nxt_ff.fwdSeen = 1'b0;
          if (!rxUiType1) begin
            // other frame types are not ours; skip quietly
            nxt_ff.st = net_param_pkg::S_SKIP;
          end else if (rxData != net_param_pkg::VERSION_SUPPORTED) begin
            nxt_ff.st = net_param_pkg::S_SKIP;
            nxt_ff.discardPulse = 1'b1;
            nxt_ff.discardCause = net_param_pkg::CAUSE_VER;
          end else begin
            nxt_ff.st = net_param_pkg::S_FIRST;
          end
        end
        net_param_pkg::S_FIRST, net_param_pkg::S_MSG_ID: begin
          if (cur_ff.st == net_param_pkg::S_FIRST && rxData == net_param_pkg::FWD_HDR_ID) begin
            // optional header announced by a zero identifier
            nxt_ff.fwdSeen = 1'b1;
            nxt_ff.st = net_param_pkg::S_FH_SRC;
          end else if (rxData >= net_param_pkg::MSG_ID_MIN && rxData <= net_param_pkg::MSG_ID_MAX) begin
            nxt_ff.msgId = rxData;
            nxt_ff.st = net_param_pkg::S_MSG_LEN;
          end else begin
            nxt_ff.st = net_param_pkg::S_SKIP;
            nxt_ff.discardPulse = 1'b1;
            nxt_ff.discardCause = net_param_pkg::CAUSE_MSG_ID;
          end
        end
        net_param_pkg::S_FH_SRC: begin
          if (!net_param_pkg::srcOk(rxData)) begin
            nxt_ff.st = net_param_pkg::S_SKIP;
            nxt_ff.discardPulse = 1'b1;
            nxt_ff.discardCause = net_param_pkg::CAUSE_FWD;
          end else begin
            nxt_ff.st = net_param_pkg::S_FH_FWD;
          end
        end
        net_param_pkg::S_FH_FWD: begin
          if (!net_param_pkg::fwdOk(rxData)) begin
            nxt_ff.st = net_param_pkg::S_SKIP;
            nxt_ff.discardPulse = 1'b1;
            nxt_ff.discardCause = net_param_pkg::CAUSE_FWD;
          end else begin
            nxt_ff.fwdAddr = rxData;
            nxt_ff.st = net_param_pkg::S_FH_DST;
          end
        end
        net_param_pkg::S_FH_DST: begin
          if (!net_param_pkg::dstOk(rxData)) begin
            nxt_ff.st = net_param_pkg::S_SKIP;
            nxt_ff.discardPulse = 1'b1;
            nxt_ff.discardCause = net_param_pkg::CAUSE_FWD;
          end else begin
            nxt_ff.dstAddr = rxData;
            nxt_ff.st = net_param_pkg::S_MSG_ID;
          end
        end
        net_param_pkg::S_MSG_LEN: begin
          // a length below the two header octets cannot describe a block
          if (rxData < net_param_pkg::BLK_HDR_LEN) begin
            nxt_ff.st = net_param_pkg::S_SKIP;
            nxt_ff.discardPulse = 1'b1;
            nxt_ff.discardCause = net_param_pkg::CAUSE_MSG_FIELD;
          end else begin
            wrBus.valid = 1'b1;
            wrBus.data = {net_param_pkg::KIND_START, cur_ff.msgId, rxData};
            nxt_ff.cnt = lenRem;
            nxt_ff.st = (lenRem == 8'h00) ? net_param_pkg::S_BLK_ID : net_param_pkg::S_MSG_DAT;
          end
        end
        net_param_pkg::S_MSG_DAT: begin
          // octets pass in arrival order, so wide fields stay high octet first
          wrBus.valid = 1'b1;
          wrBus.data = {net_param_pkg::KIND_DATA, cur_ff.msgId, rxData};
          nxt_ff.cnt = cur_ff.cnt - 8'h01;
          if (cur_ff.cnt == 8'h01) begin
            nxt_ff.st = net_param_pkg::S_BLK_ID;
          end
        end
        net_param_pkg::S_BLK_ID: begin
          nxt_ff.blkId = rxData;
          nxt_ff.st = (rxData == net_param_pkg::TERM_ID) ? net_param_pkg::S_TERM : net_param_pkg::S_BLK_LEN;
        end
        net_param_pkg::S_BLK_LEN: begin
          if (cur_ff.blkId < net_param_pkg::BLK_ID_MIN || cur_ff.blkId > net_param_pkg::BLK_ID_MAX) begin
            // undefined block: step over its body and go on
            nxt_ff.discardPulse = 1'b1;
            nxt_ff.discardCause = net_param_pkg::CAUSE_BLK_ID;
            nxt_ff.cnt = (rxData < net_param_pkg::BLK_HDR_LEN) ? 8'h00 : lenRem;
            nxt_ff.st = (rxData <= net_param_pkg::BLK_HDR_LEN) ? net_param_pkg::S_BLK_ID : net_param_pkg::S_BLK_SKIP;
          end else if (rxData < net_param_pkg::BLK_HDR_LEN) begin
            // impossible length: only this block is lost
            nxt_ff.discardPulse = 1'b1;
            nxt_ff.discardCause = net_param_pkg::CAUSE_BLK_FIELD;
            nxt_ff.st = net_param_pkg::S_BLK_ID;
          end else begin
            wrBus.valid = 1'b1;
            wrBus.data = {net_param_pkg::KIND_START, cur_ff.blkId, rxData};
            nxt_ff.cnt = lenRem;
            nxt_ff.st = (lenRem == 8'h00) ? net_param_pkg::S_BLK_ID : net_param_pkg::S_BLK_DAT;
          end
        end
        net_param_pkg::S_BLK_DAT: begin
          wrBus.valid = 1'b1;
          wrBus.data = {net_param_pkg::KIND_DATA, cur_ff.blkId, rxData};
          nxt_ff.cnt = cur_ff.cnt - 8'h01;
          if (cur_ff.cnt == 8'h01) begin
            nxt_ff.st = net_param_pkg::S_BLK_ID;
          end
        end
        net_param_pkg::S_BLK_SKIP: begin
          nxt_ff.cnt = cur_ff.cnt - 8'h01;
          if (cur_ff.cnt == 8'h01) begin
            nxt_ff.st = net_param_pkg::S_BLK_ID;
          end
        end
        net_param_pkg::S_TERM: begin
          nxt_ff.st = net_param_pkg::S_TERM;
        end
        net_param_pkg::S_SKIP: begin
          nxt_ff.st = net_param_pkg::S_SKIP;
        end
        net_param_pkg::S_CLOSE: begin
          nxt_ff.st = net_param_pkg::S_CLOSE;
        end
        default: begin
          nxt_ff.st = net_param_pkg::S_VER;
        end
      endcase
      // end of frame decides how the message closes
      if (rxLast) begin
        if (nxt_ff.st == net_param_pkg::S_SKIP) begin
          nxt_ff.st = net_param_pkg::S_VER;
        end else if (nxt_ff.st inside {net_param_pkg::S_FIRST, net_param_pkg::S_FH_SRC, net_param_pkg::S_FH_FWD,
                                       net_param_pkg::S_FH_DST, net_param_pkg::S_MSG_ID, net_param_pkg::S_MSG_LEN}) begin
          // nothing reported yet, so the message goes as a whole
          nxt_ff.st = net_param_pkg::S_VER;
          nxt_ff.discardPulse = 1'b1;
          nxt_ff.discardCause = net_param_pkg::CAUSE_MSG_FIELD;
        end else begin
          nxt_ff.st = net_param_pkg::S_CLOSE;
          if (nxt_ff.st == net_param_pkg::S_CLOSE && cur_ff.st == net_param_pkg::S_TERM) begin
            nxt_ff.closeSt = net_param_pkg::CLOSE_OK;
          end
          // items overlap on purpose: the first match wins
          priority case (1'b1)
            (nxt_ff.blkId == net_param_pkg::TERM_ID && cur_ff.st inside {net_param_pkg::S_BLK_ID,
                                                                         net_param_pkg::S_TERM}): begin
              nxt_ff.closeSt = net_param_pkg::CLOSE_OK;
            end
            (cur_ff.st == net_param_pkg::S_MSG_DAT && cur_ff.cnt != 8'h01): begin
              nxt_ff.closeSt = net_param_pkg::CLOSE_TRUNC_MSG;
              nxt_ff.discardPulse = 1'b1;
              nxt_ff.discardCause = net_param_pkg::CAUSE_TRUNC;
            end
            (cur_ff.st == net_param_pkg::S_MSG_LEN && lenRem != 8'h00): begin
              nxt_ff.closeSt = net_param_pkg::CLOSE_TRUNC_MSG;
              nxt_ff.discardPulse = 1'b1;
              nxt_ff.discardCause = net_param_pkg::CAUSE_TRUNC;
            end
            (nxt_ff.st == net_param_pkg::S_CLOSE && cur_ff.st inside {net_param_pkg::S_BLK_ID, net_param_pkg::S_BLK_LEN,
                          net_param_pkg::S_BLK_DAT, net_param_pkg::S_BLK_SKIP, net_param_pkg::S_MSG_DAT,
                          net_param_pkg::S_MSG_LEN}): begin
              // block cut short, or no terminator at all
              nxt_ff.closeSt = onBoundary ? net_param_pkg::CLOSE_NO_TERM : net_param_pkg::CLOSE_TRUNC_BLK;
              if (!onBoundary) begin
                nxt_ff.discardPulse = 1'b1;
                nxt_ff.discardCause = net_param_pkg::CAUSE_TRUNC;
              end
            end
            default: begin
              nxt_ff.closeSt = nxt_ff.closeSt;
            end
          endcase
        end
      end
    end
  end

  // single state register
  always_ff @(posedge core_clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      cur_ff <= net_param_pkg::PARSE_RESET;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // checks on the parser's own behaviour
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstSyncB);

  verDrop_a: assert property (
    take && cur_ff.st == net_param_pkg::S_VER && rxUiType1 && rxData != 8'h00 && !rxLast
    |=> discardPulse && discardCause == net_param_pkg::CAUSE_VER && cur_ff.st == net_param_pkg::S_SKIP)
    else $error("bad version not dropped");
  srcDrop_a: assert property (
    take && cur_ff.st == net_param_pkg::S_FH_SRC && !net_param_pkg::srcOk(rxData)
    |=> discardPulse && discardCause == net_param_pkg::CAUSE_FWD)
    else $error("bad source address not dropped");
  fwdDrop_a: assert property (
    take && cur_ff.st == net_param_pkg::S_FH_FWD && rxData inside {8'h01, 8'h02, 8'h03, [8'h60:8'hFF]}
    |=> discardPulse && discardCause == net_param_pkg::CAUSE_FWD)
    else $error("bad forwarder address not dropped");
  dstDrop_a: assert property (
    take && cur_ff.st == net_param_pkg::S_FH_DST && !net_param_pkg::dstOk(rxData)
    |=> discardPulse && discardCause == net_param_pkg::CAUSE_FWD)
    else $error("bad destination address not dropped");
  msgIdDrop_a: assert property (
    take && (cur_ff.st == net_param_pkg::S_MSG_ID || (cur_ff.st == net_param_pkg::S_FIRST && rxData != 8'h00)) &&
    (rxData < 8'h14 || rxData > 8'h1C)
    |=> discardPulse && discardCause == net_param_pkg::CAUSE_MSG_ID)
    else $error("bad message number not dropped");
  msgLenDrop_a: assert property (
    take && cur_ff.st == net_param_pkg::S_MSG_LEN && rxData < 8'h02 |-> !wrBus.valid ##1 discardPulse)
    else $error("bad message length not dropped");
  blkSkip_a: assert property (
    take && cur_ff.st == net_param_pkg::S_BLK_LEN && (cur_ff.blkId == 8'h00 || cur_ff.blkId > 8'h0E)
    |-> !wrBus.valid ##1 discardPulse && discardCause == net_param_pkg::CAUSE_BLK_ID)
    else $error("undefined block was reported");
  termQuiet_a: assert property (
    cur_ff.st == net_param_pkg::S_TERM |-> !wrBus.valid)
    else $error("octets after terminator were reported");
  truncBlk_a: assert property (
    take && rxLast && cur_ff.st == net_param_pkg::S_BLK_DAT && cur_ff.cnt > 8'h01
    |=> cur_ff.st == net_param_pkg::S_CLOSE && cur_ff.closeSt == net_param_pkg::CLOSE_TRUNC_BLK)
    else $error("short block not closed as truncated");
  relayFire_a: assert property (
    relayPulse |-> $past(cur_ff.fwdSeen) && $past(established) && $past(cur_ff.fwdAddr) == $past(ownLinkAddr)
    && relayDst == $past(cur_ff.dstAddr))
    else $error("relay without matching forwarder");
  closeHold_a: assert property (
    cur_ff.st == net_param_pkg::S_CLOSE && !wrBus.ready |=> cur_ff.st == net_param_pkg::S_CLOSE && !rxReady)
    else $error("close entry lost under back-pressure");

  okClose_c: cover property (cur_ff.st == net_param_pkg::S_CLOSE && cur_ff.closeSt == net_param_pkg::CLOSE_OK
                             && wrBus.ready);
  relay_c: cover property (relayPulse);
  blkSkip_c: cover property (discardPulse && discardCause == net_param_pkg::CAUSE_BLK_ID);
  stall_c: cover property ((rxValid && !wrBus.ready) [*3]);
endmodule : net_param_msg_parser

/* File: rtl/net_param_pkg.sv */
// Purpose: shared constants, types and helpers of the parameter message parser
// Assumes: octets arrive one per beat on a byte stream
// Notes: lengths count the whole block, identifier and length octets included
package net_param_pkg;
  // protocol values
  localparam logic [7:0] VERSION_SUPPORTED = 8'h00;
  localparam logic [7:0] FWD_HDR_ID = 8'h00;
  localparam logic [7:0] MSG_ID_MIN = 8'h14;
  localparam logic [7:0] MSG_ID_MAX = 8'h1C;
  localparam logic [7:0] BLK_ID_MIN = 8'h01;
  localparam logic [7:0] BLK_ID_MAX = 8'h0E;
  localparam logic [7:0] TERM_ID = 8'hFF;
  localparam logic [7:0] ADDR_UNKNOWN = 8'h00;
  localparam logic [7:0] ADDR_ONE = 8'h01;
  localparam logic [7:0] ADDR_TWO = 8'h02;
  localparam logic [7:0] ADDR_MIN = 8'h04;
  localparam logic [7:0] ADDR_MAX = 8'h5F;
  localparam logic [7:0] ADDR_GLOBAL = 8'h7F;
  localparam logic [7:0] BLK_HDR_LEN = 8'h02;
  // buffer entry layout: kind, field a, field b
  localparam int ENTRY_W = 18;
  localparam int FIFO_DEPTH = 8;
  localparam logic [1:0] KIND_START = 2'h0;
  localparam logic [1:0] KIND_DATA = 2'h1;
  localparam logic [1:0] KIND_CLOSE = 2'h2;
  // close status
  localparam logic [1:0] CLOSE_OK = 2'h0;
  localparam logic [1:0] CLOSE_TRUNC_MSG = 2'h1;
  localparam logic [1:0] CLOSE_TRUNC_BLK = 2'h2;
  localparam logic [1:0] CLOSE_NO_TERM = 2'h3;
  // discard causes
  localparam logic [2:0] CAUSE_NONE = 3'h0;
  localparam logic [2:0] CAUSE_VER = 3'h1;
  localparam logic [2:0] CAUSE_FWD = 3'h2;
  localparam logic [2:0] CAUSE_MSG_ID = 3'h3;
  localparam logic [2:0] CAUSE_MSG_FIELD = 3'h4;
  localparam logic [2:0] CAUSE_BLK_ID = 3'h5;
  localparam logic [2:0] CAUSE_BLK_FIELD = 3'h6;
  localparam logic [2:0] CAUSE_TRUNC = 3'h7;
  localparam logic [1:0] RST_PIPE_INIT = 2'h0;

  typedef enum logic [3:0] {
    S_VER, S_FIRST, S_FH_SRC, S_FH_FWD, S_FH_DST, S_MSG_ID, S_MSG_LEN, S_MSG_DAT,
    S_BLK_ID, S_BLK_LEN, S_BLK_DAT, S_BLK_SKIP, S_TERM, S_SKIP, S_CLOSE
  } parse_e;

  typedef struct packed {
    parse_e st;
    logic [7:0] cnt;
    logic [7:0] msgId;
    logic [7:0] blkId;
    logic fwdSeen;
    logic [7:0] fwdAddr;
    logic [7:0] dstAddr;
    logic [1:0] closeSt;
    logic discardPulse;
    logic [2:0] discardCause;
    logic relayPulse;
    logic [7:0] relayDst;
  } parse_s;

  localparam parse_s PARSE_RESET = '{st: S_VER, default: '0};

  // address range helpers
  function automatic logic inRange(input logic [7:0] a);
    return (a >= ADDR_MIN) && (a <= ADDR_MAX);
  endfunction : inRange
  function automatic logic srcOk(input logic [7:0] a);
    return (a == ADDR_ONE) || (a == ADDR_TWO) || inRange(a);
  endfunction : srcOk
  function automatic logic fwdOk(input logic [7:0] a);
    return (a == ADDR_UNKNOWN) || inRange(a);
  endfunction : fwdOk
  function automatic logic dstOk(input logic [7:0] a);
    return srcOk(a) || (a == ADDR_GLOBAL);
  endfunction : dstOk
endpackage : net_param_pkg

/* File: rtl/stream_if.sv */
// Purpose: valid/ready word stream into and out of the parser's buffer
// Assumes: one clock for both ends
// Notes: a word moves when valid and ready are both high
`timescale 1ns/1ps
interface stream_if #(parameter int W = 18);
  logic valid; // word offered
  logic ready; // word accepted
  logic [W-1:0] data; // payload
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface : stream_if

/* File: test/frame_src.sv */
// Purpose: link-side source of received octets
// Assumes: octets change only just after a rising edge
// Notes: released data shows the inverse of the last octet
`timescale 1ns/1ps
module frame_src (
  input wire logic clk,
  input wire logic rxReady,
  output logic [7:0] rxData,
  output logic rxValid,
  output logic rxLast,
  output logic rxUiType1
);
  initial begin
    {rxValid, rxLast, rxData} = '0;
    rxUiType1 = 1'b1;
  end
  // each octet held until the edge that takes it
  task automatic send(input logic [7:0] f[$]);
    foreach (f[i]) begin
      rxValid <= 1'b1;
      rxData <= f[i];
      rxLast <= (i == f.size() - 1);
      @(posedge clk);
      while (rxReady !== 1'b1) @(posedge clk);
    end
    {rxValid, rxLast} <= 2'h0;
    rxData <= ~f[$]; // stale octet must never look valid
  endtask : send
  // frame type flag for the next frame, sampled with its first octet
  task automatic setType(input logic t);
    rxUiType1 <= t;
  endtask : setType
endmodule : frame_src

/* File: test/net_param_msg_parser_tb.sv */
// Purpose: self-checking bench of the message parser
// Assumes: entries compared as {kind, a, b}
// Notes: own link address 5, station established except in the noestab run
`timescale 1ns/1ps
module net_param_msg_parser_tb;
  logic core_clk, rst_b, rxReady, blkValid, blkReady, discardPulse, relayPulse, rxValid, rxLast, rxUiType1;
  logic [7:0] rxData, blkA, blkB, relayDst, lastDst;
  logic [1:0] blkKind;
  logic established; // station membership seen by the relay logic
  logic [2:0] discardCause, lastCause;
  logic [17:0] got[$]; // entries taken by the sink
  int miscompares, cmp_count, cycles, nDisc, nRelay;
  frame_src i_src(.clk(core_clk), .rxReady(rxReady), .rxData(rxData), .rxValid(rxValid), .rxLast(rxLast),
    .rxUiType1(rxUiType1));
  net_param_msg_parser i_dut(.core_clk(core_clk), .rst_b(rst_b), .rxData(rxData), .rxValid(rxValid),
    .rxLast(rxLast), .rxUiType1(rxUiType1), .rxReady(rxReady), .ownLinkAddr(8'h05), .established(established),
    .blkValid(blkValid), .blkReady(blkReady), .blkKind(blkKind), .blkA(blkA), .blkB(blkB),
    .discardPulse(discardPulse), .discardCause(discardCause), .relayPulse(relayPulse), .relayDst(relayDst));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // sink, pulse monitor and hang limit
  always @(posedge core_clk) begin
    cycles++;
    if (blkValid === 1'b1 && blkReady === 1'b1) got.push_back({blkKind, blkA, blkB});
    if (discardPulse === 1'b1) begin
      nDisc++;
      lastCause = discardCause;
    end
    if (relayPulse === 1'b1) begin
      nRelay++;
      lastDst = relayDst;
    end
    if (cycles == 4000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic check(input string nm, input logic [17:0] e, input logic [17:0] s);
    cmp_count++;
    if (e !== s) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  // send one frame, then judge entries and pulses
  task automatic run(input string nm, input logic [7:0] f[$], input logic [17:0] e[$], input int d,
    input logic [2:0] c, input int r);
    got.delete();
    nDisc = 0;
    nRelay = 0;
    i_src.send(f);
    for (int k = 0; k < 40 && got.size() < e.size(); k++) @(posedge core_clk);
    repeat (3) @(posedge core_clk); // pulses come no later than the close entry; margin only
    check(nm, 18'(e.size()), 18'(got.size()));
    foreach (e[i]) if (i < got.size()) check(nm, e[i], got[i]);
    check(nm, 18'(d), 18'(nDisc));
    if (d > 0) check(nm, 18'(c), 18'(lastCause));
    check(nm, 18'(r), 18'(nRelay));
    $display("test %s done", nm);
  endtask : run
  // buffer fills while the sink stalls, then drains
  task automatic t_fill();
    logic [7:0] f[$] = '{8'h00, 8'h14, 8'h0C};
    logic [17:0] e[$] = '{18'h0140C};
    for (int i = 0; i < 10; i++) begin
      f.push_back(8'(i));
      e.push_back(18'h11400 + 18'(i));
    end
    f.push_back(8'hFF);
    e.push_back(18'h20014);
    blkReady <= 1'b0;
    fork
      run("fill", f, e, 0, 3'h0, 0);
      begin
        repeat (30) @(posedge core_clk);
        check("stall", 18'h0, 18'(rxReady));
        blkReady <= 1'b1;
      end
    join
  endtask : t_fill
  initial begin
    rst_b = 1'b0;
    blkReady = 1'b1;
    established = 1'b1;
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    run("plain", '{8'h00, 8'h14, 8'h03, 8'hAA, 8'hFF, 8'h01, 8'h03, 8'h44},
      '{18'h01403, 18'h114AA, 18'h20014}, 0, 3'h0, 0);
    run("version", '{8'h01, 8'h14, 8'h02, 8'hFF}, '{}, 1, 3'h1, 0);
    run("msgid", '{8'h00, 8'h1D, 8'h02, 8'hFF}, '{}, 1, 3'h3, 0);
    run("fwd", '{8'h00, 8'h00, 8'h05, 8'h03, 8'h07, 8'h14, 8'h02, 8'hFF}, '{}, 1, 3'h2, 0);
    run("blkid", '{8'h00, 8'h14, 8'h02, 8'h0F, 8'h03, 8'h55, 8'h01, 8'h03, 8'h66, 8'hFF},
      '{18'h01402, 18'h00103, 18'h10166, 18'h20014}, 1, 3'h5, 0);
    run("trunc", '{8'h00, 8'h14, 8'h02, 8'h01, 8'h05, 8'h77, 8'hFF},
      '{18'h01402, 18'h00105, 18'h10177, 18'h101FF, 18'h20214}, 1, 3'h7, 0);
    run("relay", '{8'h00, 8'h00, 8'h05, 8'h05, 8'h07, 8'h14, 8'h02, 8'hFF},
      '{18'h01402, 18'h28014}, 0, 3'h0, 1);
    check("relay dst", 18'h7, 18'(lastDst));
    run("msglen", '{8'h00, 8'h14, 8'h01, 8'hFF}, '{}, 1, 3'h4, 0);
    run("msgcut", '{8'h00, 8'h14, 8'h05, 8'hAA, 8'hBB},
      '{18'h01405, 18'h114AA, 18'h114BB, 18'h20114}, 1, 3'h7, 0);
    run("blklen", '{8'h00, 8'h14, 8'h02, 8'h01, 8'h01, 8'hFF}, '{18'h01402, 18'h20014}, 1, 3'h6, 0);
    run("src", '{8'h00, 8'h00, 8'h03, 8'h05, 8'h07, 8'h14, 8'h02, 8'hFF}, '{}, 1, 3'h2, 0);
    run("dst", '{8'h00, 8'h00, 8'h05, 8'h05, 8'h60, 8'h14, 8'h02, 8'hFF}, '{}, 1, 3'h2, 0);
    i_src.setType(1'b0);
    run("type", '{8'h00, 8'h14, 8'h02, 8'hFF}, '{}, 0, 3'h0, 0);
    i_src.setType(1'b1);
    established <= 1'b0;
    run("noestab", '{8'h00, 8'h00, 8'h05, 8'h05, 8'h07, 8'h14, 8'h02, 8'hFF},
      '{18'h01402, 18'h20014}, 0, 3'h0, 0);
    established <= 1'b1;
    t_fill();
    complete_run();
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
endmodule : net_param_msg_parser_tb
